//--- bm_ctrl.sv
// Operation
// - Decode 16-byte window at configured base.
// - Byte, word, dword access to every register.
// - Reserved bits ignore writes, read zero.
// - Primary descriptor pointer at bytes 04-07.
// - Secondary descriptor pointer at bytes 0C-0F.
// - Command bytes at 00h/08h, reset zero.
// - Command bits 7:4, 2:1 read zero.
// - Command bit 3 selects transfer direction.
// - Start only on start bit rising.
// - Transfer only while start bit set.
// - Clearing start pulses discard; status, pointer kept.
// - Clear during active, no irq: abort.
// - Status bit 2 set on irq edge.
// - Status bit 1 set on host abort.
`timescale 1ns/1ps

module bm_ctrl
    import bm_ctrl_pkg::*;
(
    input  wire logic                  i_clk,
    input  wire logic                  i_reset,
    // Host I/O access, window base comes from configuration space.
    input  wire logic [15:0]           i_dma_window_base_pointer,
    input  wire logic [15:0]           i_io_addr,
    input  wire logic [3:0]            i_io_byte_en,
    input  wire logic                  i_io_write,
    input  wire logic                  i_io_read,
    input  wire logic [31:0]           i_io_wdata,
    output logic [31:0]                o_io_rdata,
    output logic                       o_io_claim,
    // Engine side, index 0 is primary, 1 is secondary.
    input  wire logic [CHANNELS-1:0]   i_engine_active,
    input  wire logic [CHANNELS-1:0]   i_drive_irq,
    input  wire logic [CHANNELS-1:0]   i_host_bus_abort,
    output logic [CHANNELS-1:0]        o_start_pulse,
    output logic [CHANNELS-1:0]        o_run,
    output logic [CHANNELS-1:0]        o_transfer_direction,
    output logic [CHANNELS-1:0]        o_abort_pulse,
    output logic [CHANNELS-1:0]        o_discard_state,
    output logic [CHANNELS*32-1:0]     o_descriptor_pointer
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic                 hit;
    logic                 wr_hit;
    logic [CHANNELS-1:0]  ctl_sel;
    logic [CHANNELS-1:0]  ptr_sel;

    logic [7:0]           cmd       [CHANNELS];
    logic [7:0]           stat      [CHANNELS];
    logic [CHANNELS-1:0]  stat_active;
    logic [CHANNELS-1:0]  stat_irq;
    logic [CHANNELS-1:0]  stat_error;
    logic [1:0]           stat_cap  [CHANNELS];
    logic [31:0]          ptr       [CHANNELS];
    logic [CHANNELS-1:0]  irq_prev;

    assign hit = (i_io_addr[15:4] == i_dma_window_base_pointer[15:4])
                 && (i_io_read || i_io_write);
    assign wr_hit = hit && i_io_write;

    always_comb begin
        // command and status share one dword
        ctl_sel[0] = i_io_addr[3:2] == OFS_PRIMARY_CMD[3:2];
        ctl_sel[1] = i_io_addr[3:2] == OFS_SECONDARY_CMD[3:2];
        ptr_sel[0] = i_io_addr[3:2] == OFS_PRIMARY_PTR[3:2];
        ptr_sel[1] = i_io_addr[3:2] == OFS_SECONDARY_PTR[3:2];
    end

    // ------------------------------------------------------------------
    // Command bytes
    // ------------------------------------------------------------------
    logic [7:0]           next_cmd  [CHANNELS];
    logic [7:0]           next_stat [CHANNELS];
    logic [CHANNELS-1:0]  cmd_wr;
    logic [CHANNELS-1:0]  stat_wr;

    always_comb begin
        for (int c = 0; c < CHANNELS; c++) begin
            cmd_wr[c]    = wr_hit && ctl_sel[c] && i_io_byte_en[LANE_CMD];
            stat_wr[c]   = wr_hit && ctl_sel[c] && i_io_byte_en[LANE_STAT];
            next_cmd[c]  = i_io_wdata[8*LANE_CMD +: 8] & CMD_WRITABLE;
            next_stat[c] = i_io_wdata[8*LANE_STAT +: 8];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            for (int c = 0; c < CHANNELS; c++) begin
                cmd[c] <= CMD_RESET;
            end
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                if (cmd_wr[c]) begin
                    cmd[c] <= next_cmd[c];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Engine control strobes
    // ------------------------------------------------------------------
    // Every strobe is its own flop; all of them settle on the edge that
    // takes the command write, so the engine sees one consistent picture.

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_start_pulse <= '0;
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                o_start_pulse[c] <= cmd_wr[c]
                    && next_cmd[c][CMD_START_BIT]
                    && !cmd[c][CMD_START_BIT];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_discard_state <= '0;
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                o_discard_state[c] <= cmd_wr[c]
                    && !next_cmd[c][CMD_START_BIT]
                    && cmd[c][CMD_START_BIT];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_abort_pulse <= '0;
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                o_abort_pulse[c] <= cmd_wr[c]
                    && !next_cmd[c][CMD_START_BIT]
                    && cmd[c][CMD_START_BIT]
                    && stat_active[c]
                    && !stat_irq[c];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_run <= '0;
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                o_run[c] <= cmd_wr[c] ? next_cmd[c][CMD_START_BIT]
                                      : cmd[c][CMD_START_BIT];
            end
        end
    end

    // The direction bit is passed on as written; software keeps it still
    // while a channel runs, so no interlock is spent on it.
    // direction, 1 writes memory
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_transfer_direction <= '0;
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                o_transfer_direction[c] <= cmd_wr[c]
                    ? next_cmd[c][CMD_DIR_BIT] : cmd[c][CMD_DIR_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // Status bytes
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            irq_prev <= '0;
        end else begin
            irq_prev <= i_drive_irq;
        end
    end

    // Active is a registered copy, one clock behind the engine.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            stat_active <= {CHANNELS{STAT_RESET[STAT_ACTIVE_BIT]}};
        end else begin
            stat_active <= i_engine_active;
        end
    end

    // set on edge, set beats clear
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            stat_irq <= {CHANNELS{STAT_RESET[STAT_IRQ_BIT]}};
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                if (i_drive_irq[c] && !irq_prev[c]) begin
                    stat_irq[c] <= 1'b1;
                end else if (stat_wr[c] && next_stat[c][STAT_IRQ_BIT]) begin
                    stat_irq[c] <= 1'b0;
                end
            end
        end
    end

    // host abort sets error, set wins
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            stat_error <= {CHANNELS{STAT_RESET[STAT_ERROR_BIT]}};
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                if (i_host_bus_abort[c]) begin
                    stat_error[c] <= 1'b1;
                end else if (stat_wr[c] && next_stat[c][STAT_ERROR_BIT]) begin
                    stat_error[c] <= 1'b0;
                end
            end
        end
    end

    // capable bits follow the status lane
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            for (int c = 0; c < CHANNELS; c++) begin
                stat_cap[c] <= {STAT_RESET[STAT_CAP1_BIT],
                                STAT_RESET[STAT_CAP0_BIT]};
            end
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                if (stat_wr[c]) begin
                    stat_cap[c] <= {next_stat[c][STAT_CAP1_BIT],
                                    next_stat[c][STAT_CAP0_BIT]};
                end
            end
        end
    end

    // bits with no flop behind them read zero
    always_comb begin
        for (int c = 0; c < CHANNELS; c++) begin
            stat[c]                  = STAT_RESET;
            stat[c][STAT_ACTIVE_BIT] = stat_active[c];
            stat[c][STAT_ERROR_BIT]  = stat_error[c];
            stat[c][STAT_IRQ_BIT]    = stat_irq[c];
            stat[c][STAT_CAP0_BIT]   = stat_cap[c][0];
            stat[c][STAT_CAP1_BIT]   = stat_cap[c][1];
        end
    end

    // ------------------------------------------------------------------
    // Descriptor pointers
    // ------------------------------------------------------------------
    // each byte lane written on its own enable
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            for (int c = 0; c < CHANNELS; c++) begin
                ptr[c] <= PTR_RESET;
            end
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                for (int b = 0; b < 4; b++) begin
                    if (wr_hit && ptr_sel[c] && i_io_byte_en[b]) begin
                        ptr[c][8*b +: 8] <= i_io_wdata[8*b +: 8];
                    end
                end
            end
        end
    end

    always_comb begin
        for (int c = 0; c < CHANNELS; c++) begin
            o_descriptor_pointer[32*c +: 32] = ptr[c];
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Read data is registered, so it appears one clock after the request.
    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = 32'h0000_0000;
        for (int c = 0; c < CHANNELS; c++) begin
            if (ctl_sel[c]) begin
                next_rdata = {8'h00, stat[c], 8'h00, cmd[c]};
            end else if (ptr_sel[c]) begin
                next_rdata = ptr[c];
            end
        end
        for (int b = 0; b < 4; b++) begin
            if (!i_io_byte_en[b]) begin
                next_rdata[8*b +: 8] = 8'h00;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_io_rdata <= 32'h0000_0000;
            o_io_claim <= 1'b0;
        end else begin
            o_io_claim <= hit;
            if (hit && i_io_read) begin
                o_io_rdata <= next_rdata;
            end else begin
                o_io_rdata <= 32'h0000_0000;
            end
        end
    end

endmodule

//--- bm_ctrl_chk.sv
`timescale 1ns/1ps
module bm_ctrl_chk
    import bm_ctrl_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_reset,
    input wire logic [15:0] i_dma_window_base_pointer,
    input wire logic [15:0] i_io_addr,
    input wire logic [3:0]  i_io_byte_en,
    input wire logic        i_io_write,
    input wire logic        i_io_read,
    input wire logic [31:0] i_io_wdata,
    input wire logic [31:0] o_io_rdata,
    input wire logic        o_io_claim,
    input wire logic [1:0]  o_start_pulse,
    input wire logic [1:0]  o_run,
    input wire logic [1:0]  o_transfer_direction,
    input wire logic [1:0]  o_abort_pulse,
    input wire logic [1:0]  o_discard_state,
    input wire logic [63:0] o_descriptor_pointer
);
    logic hit;
    assign hit = i_io_addr[15:4] == i_dma_window_base_pointer[15:4];
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    sequence s_cmd_wr;
        i_io_write && hit && i_io_addr[3:2] == 2'd0 && i_io_byte_en[0];
    endsequence
    sequence s_ptr_wr;
        i_io_write && hit && i_io_addr[3:2] == 2'd1 && i_io_byte_en == 4'hf;
    endsequence
    property p_claim;
        o_io_claim == $past((i_io_read || i_io_write) && hit);
    endproperty
    a_claim: assert property (p_claim) else $error("claim wrong");
    property p_idle;
        !$past(i_io_read && hit) |-> o_io_rdata == 32'h0000_0000;
    endproperty
    a_idle: assert property (p_idle) else $error("rdata not idle");
    property p_resv;
        i_io_read && hit && !i_io_addr[2] |=> o_io_rdata[7:4] == 4'h0
            && o_io_rdata[2:1] == 2'h0 && o_io_rdata[15:8] == 8'h00;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved set");
    property p_cmd;
        s_cmd_wr |=> o_run[0] == $past(i_io_wdata[0])
            && o_transfer_direction[0] == $past(i_io_wdata[3]);
    endproperty
    a_cmd: assert property (p_cmd) else $error("command wrong");
    property p_start;
        o_start_pulse[0] == (o_run[0] && !$past(o_run[0]));
    endproperty
    a_start: assert property (p_start) else $error("start wrong");
    property p_disc;
        o_discard_state[1] == ($past(o_run[1]) && !o_run[1]);
    endproperty
    a_disc: assert property (p_disc) else $error("discard wrong");
    property p_abort;
        o_abort_pulse[1] |-> o_discard_state[1] && !o_run[1];
    endproperty
    a_abort: assert property (p_abort) else $error("abort wrong");
    property p_ptr;
        s_ptr_wr |=> o_descriptor_pointer[31:0] == $past(i_io_wdata);
    endproperty
    a_ptr: assert property (p_ptr) else $error("pointer wrong");
endmodule
bind bm_ctrl bm_ctrl_chk chk_u (
    .i_clk                     (i_clk),
    .i_reset                   (i_reset),
    .i_dma_window_base_pointer (i_dma_window_base_pointer),
    .i_io_addr                 (i_io_addr),
    .i_io_byte_en              (i_io_byte_en),
    .i_io_write                (i_io_write),
    .i_io_read                 (i_io_read),
    .i_io_wdata                (i_io_wdata),
    .o_io_rdata                (o_io_rdata),
    .o_io_claim                (o_io_claim),
    .o_start_pulse             (o_start_pulse),
    .o_run                     (o_run),
    .o_transfer_direction      (o_transfer_direction),
    .o_abort_pulse             (o_abort_pulse),
    .o_discard_state           (o_discard_state),
    .o_descriptor_pointer      (o_descriptor_pointer)
);

//--- bm_ctrl_pkg.sv
package bm_ctrl_pkg;

    // ------------------------------------------------------------------
    // Window layout
    // ------------------------------------------------------------------
    localparam int unsigned WINDOW_BYTES      = 16;
    localparam int unsigned CHANNELS          = 2;
    localparam logic [3:0]  OFS_PRIMARY_CMD   = 4'h0;
    localparam logic [3:0]  OFS_PRIMARY_STAT  = 4'h2;
    localparam logic [3:0]  OFS_PRIMARY_PTR   = 4'h4;
    localparam logic [3:0]  OFS_SECONDARY_CMD = 4'h8;
    localparam logic [3:0]  OFS_SECONDARY_STAT = 4'hA;
    localparam logic [3:0]  OFS_SECONDARY_PTR = 4'hC;
    // Configuration offset of the window base register (placed outside).
    localparam logic [7:0]  CFG_OFS_WINDOW_BASE = 8'h20;

    // ------------------------------------------------------------------
    // Byte lanes inside the control word of a channel
    // ------------------------------------------------------------------
    localparam int unsigned LANE_CMD  = 0;
    localparam int unsigned LANE_STAT = 2;

    // ------------------------------------------------------------------
    // Command byte fields
    // ------------------------------------------------------------------
    localparam int unsigned CMD_START_BIT = 0;
    localparam int unsigned CMD_DIR_BIT   = 3;
    localparam logic [7:0]  CMD_WRITABLE  = 8'h09;
    localparam logic [7:0]  CMD_RESET     = 8'h00;

    // ------------------------------------------------------------------
    // Status byte fields
    // ------------------------------------------------------------------
    localparam int unsigned STAT_ACTIVE_BIT = 0;
    localparam int unsigned STAT_ERROR_BIT  = 1;
    localparam int unsigned STAT_IRQ_BIT    = 2;
    localparam int unsigned STAT_CAP0_BIT   = 5;
    localparam int unsigned STAT_CAP1_BIT   = 6;
    localparam logic [7:0]  STAT_RESET      = 8'h00;

    // ------------------------------------------------------------------
    // Descriptor pointer
    // ------------------------------------------------------------------
    localparam logic [31:0] PTR_RESET = 32'h0000_0000;

endpackage

//--- bm_ctrl_tb.sv
`timescale 1ns/1ps
module bm_ctrl_tb;
    import bm_ctrl_pkg::*;
    localparam logic [15:0] BASE = 16'hc000;
    logic             clk;
    logic             reset = 1'b1;
    logic [1:0]       active = 2'b00, irq = 2'b00, berr = 2'b00;
    logic [15:0]      addr;
    logic [3:0]       be;
    logic             wr, rd, claim, c;
    logic [31:0]      wdata, rdata, q;
    int               error_cnt = 0;
    int               comparisons = 0;
    bm_host host_u (.i_clk(clk), .i_io_rdata(rdata), .i_io_claim(claim),
        .o_io_addr(addr), .o_io_byte_en(be), .o_io_write(wr),
        .o_io_read(rd), .o_io_wdata(wdata));
    bm_ctrl dut_u (.i_clk(clk), .i_reset(reset),
        .i_dma_window_base_pointer(BASE), .i_io_addr(addr),
        .i_io_byte_en(be), .i_io_write(wr), .i_io_read(rd),
        .i_io_wdata(wdata), .o_io_rdata(rdata), .o_io_claim(claim),
        .i_engine_active(active), .i_drive_irq(irq),
        .i_host_bus_abort(berr), .o_start_pulse(), .o_run(),
        .o_transfer_direction(), .o_abort_pulse(), .o_discard_state(),
        .o_descriptor_pointer());
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic w(input logic [3:0] o, input logic [3:0] b,
                     input logic [31:0] d);
        host_u.xfer(1'b1, BASE + 16'(o), b, d, q, c);
    endtask
    task automatic rdc(input logic [3:0] o, input logic [3:0] b,
                       input logic [31:0] e);
        host_u.xfer(1'b0, BASE + 16'(o), b, 32'h0000_0000, q, c);
        chk("rdata", e, q);
        chk("claim", 1'b1, c);
    endtask
    task automatic wrap_up;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic s_reset;
        for (int i = 0; i < 16; i += 4) rdc(4'(i), 4'hf, 32'h0);
        host_u.xfer(1'b0, BASE + 16'h0010, 4'hf, 32'h0, q, c);
        chk("claim", 1'b0, c);
    endtask
    task automatic s_ptr;
        w(4'h4, 4'hf, 32'h1234_5678);
        w(4'h4, 4'h4, 32'h00ab_0000);
        rdc(4'h4, 4'hf, 32'h12ab_5678);
        w(4'hc, 4'hf, 32'h0000_beef);
        w(4'hc, 4'hc, 32'hcafe_0000);
        rdc(4'hc, 4'h2, 32'h0000_be00);
        chk("ptr", 32'hcafe_beef, dut_u.o_descriptor_pointer[63:32]);
    endtask
    task automatic s_cmd;
        w(4'h0, 4'hf, 32'hffff_ffff);
        chk("start", 1'b1, dut_u.o_start_pulse[0]);
        chk("dir", 1'b1, dut_u.o_transfer_direction[0]);
        rdc(4'h0, 4'hf, 32'h0060_0009);
        w(4'h0, 4'h1, 32'h0000_0009);
        chk("start", 1'b0, dut_u.o_start_pulse[0]);
        w(4'h0, 4'h1, 32'h0000_0008);
        chk("discard", 1'b1, dut_u.o_discard_state[0]);
        chk("run", 1'b0, dut_u.o_run[0]);
        w(4'h0, 4'h1, 32'h0000_0001);
        chk("start", 1'b1, dut_u.o_start_pulse[0]);
        chk("dir", 1'b0, dut_u.o_transfer_direction[0]);
    endtask
    task automatic s_abort;
        @(posedge clk);
        active[1] <= 1'b1;
        w(4'h8, 4'h1, 32'h0000_0001);
        w(4'h8, 4'h1, 32'h0000_0000);
        chk("abort", 1'b1, dut_u.o_abort_pulse[1]);
        @(posedge clk);
        irq[1] <= 1'b1;
        repeat (3) @(posedge clk);
        rdc(4'h8, 4'h4, 32'h0005_0000);
        w(4'h8, 4'h1, 32'h0000_0001);
        w(4'h8, 4'h1, 32'h0000_0000);
        chk("abort", 1'b0, dut_u.o_abort_pulse[1]);
        w(4'h8, 4'h4, 32'h0004_0000);
        rdc(4'h8, 4'h4, 32'h0001_0000);
        @(posedge clk);
        berr[1] <= 1'b1;
        @(posedge clk);
        berr[1] <= 1'b0;
        rdc(4'h8, 4'h4, 32'h0003_0000);
        w(4'h8, 4'h4, 32'h0002_0000);
        rdc(4'h8, 4'h4, 32'h0001_0000);
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (2000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        s_reset();
        s_ptr();
        s_cmd();
        s_abort();
        wrap_up();
    end
endmodule

//--- bm_host.sv
`timescale 1ns/1ps
module bm_host (
    input  wire logic        i_clk,
    input  wire logic [31:0] i_io_rdata,
    input  wire logic        i_io_claim,
    output logic [15:0]      o_io_addr    = 16'h0000,
    output logic [3:0]       o_io_byte_en = 4'h0,
    output logic             o_io_write   = 1'b0,
    output logic             o_io_read    = 1'b0,
    output logic [31:0]      o_io_wdata   = 32'h0000_0000
);
    // Released data is inverted so a stale value can never read back.
    task automatic xfer(input logic w, input logic [15:0] a,
                        input logic [3:0] be, input logic [31:0] d,
                        output logic [31:0] q, output logic c);
        @(posedge i_clk);
        o_io_addr    <= a;
        o_io_byte_en <= be;
        o_io_write   <= w;
        o_io_read    <= !w;
        o_io_wdata   <= d;
        @(posedge i_clk);
        o_io_write   <= 1'b0;
        o_io_read    <= 1'b0;
        o_io_wdata   <= ~d;
        #1;
        q = i_io_rdata;
        c = i_io_claim;
    endtask
endmodule
